// [tb_tmr_auto_reload.sv]
// Testbench for the auto-reload timer over its Avalon-MM register port.
// Assumes tmr_far_end drives the pins; the bench drives timer 1 overflow pulses.
`timescale 1ns/1ns
module tb_tmr_auto_reload
  import tmr_pkg::*;
;
  logic i_clk = 1'h0;
  logic i_resetn = 1'h0;
  logic [TMR_ADDR_W-1:0] adr = '0;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [TMR_DATA_W-1:0] wd = '0;
  logic [TMR_DATA_W-1:0] rdata;
  logic wreq, trig, cpin, rx, tx;
  logic [7:0] q;
  logic [3:0] be = 4'h1;
  logic [1:0] alo = 2'h0;
  logic t1ov = 1'h0;
  logic ovp, oflag, eflag;
  int ovp_n = 0;
  int rx0, tx0, ov0;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;

  tmr_auto_reload #(.TICK_DIV(2)) tmr_auto_reload_i (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wreq),
    .i_external_trigger_pin(trig), .i_count_pin(cpin), .i_t1_overflow(t1ov),
    .o_rx_baud_tick(rx), .o_tx_baud_tick(tx), .o_overflow_pulse(ovp),
    .o_overflow_flag(oflag), .o_external_event_flag(eflag));
  tmr_far_end tmr_far_end_i (.i_clk(i_clk), .i_rx_baud_tick(rx), .i_tx_baud_tick(tx),
    .o_trigger_pin(trig), .o_count_pin(cpin));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    ovp_n <= ovp_n + int'(ovp);
  end
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    adr <= {idx, alo};
    wr <= w;
    rd <= ~w;
    wd <= {24'h00_0000, d};
    do begin
      @(posedge i_clk);
    end while (wreq !== 1'h0);
    q = rdata[7:0];
    wr <= 1'h0;
    rd <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic wr8(input logic [7:0] idx, input logic [7:0] d);
    acc(1'h1, idx, d);
  endtask
  task automatic rd8(input logic [7:0] idx, input logic [7:0] exp);
    acc(1'h0, idx, 8'h00);
    checked++;
    if (q !== exp) begin
      num_errors++;
      $display("mismatch at %0t: reg %h got %h want %h", $time, idx, q, exp);
    end
  endtask
  task automatic chk_rng(input int got, input int mn, input int mx);
    checked++;
    if (got < mn || got > mx) begin
      num_errors++;
      $display("mismatch at %0t: ticks %0d not in %0d..%0d", $time, got, mn, mx);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: flag %b want %b", $time, got, exp);
    end
  endtask
  // Five single-cycle timer 1 overflow pulses over 100 cycles
  task automatic pulse_t1();
    repeat (5) begin
      t1ov <= 1'h1;
      @(posedge i_clk);
      t1ov <= 1'h0;
      repeat (19) @(posedge i_clk);
    end
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'h1;
    @(posedge i_clk);
    rd8(TMR_IDX_CTRL, 8'h00);
    rd8(8'h10, 8'h00);
    be <= 4'h0;
    wr8(TMR_IDX_RELOAD_LO, 8'hAA);
    be <= 4'h1;
    rd8(TMR_IDX_RELOAD_LO, 8'h00);
    wr8(TMR_IDX_RELOAD_LO, 8'hF0);
    wr8(TMR_IDX_RELOAD_HI, 8'hFF);
    wr8(TMR_IDX_COUNT_LO, 8'hFC);
    wr8(TMR_IDX_COUNT_HI, 8'hFF);
    wr8(TMR_IDX_CTRL, 8'h04);
    repeat (30) @(posedge i_clk);
    rd8(TMR_IDX_CTRL, 8'h84);
    chk_bit(oflag, 1'b1);
    rd8(TMR_IDX_COUNT_HI, 8'hFF);
    // Stop first so no rollover lands on the clear
    wr8(TMR_IDX_CTRL, 8'h80);
    wr8(TMR_IDX_CTRL, 8'h00);
    rd8(TMR_IDX_CTRL, 8'h00);
    chk_bit(oflag, 1'b0);
    wr8(TMR_IDX_COUNT_LO, 8'h55);
    repeat (10) @(posedge i_clk);
    rd8(TMR_IDX_COUNT_LO, 8'h55);
    wr8(TMR_IDX_CTRL, 8'h08);
    alo = 2'h1;
    rd8(TMR_IDX_CTRL, 8'h00);
    wr8(TMR_IDX_CTRL, 8'h00);
    alo = 2'h0;
    rd8(TMR_IDX_CTRL, 8'h08);
    wr8(TMR_IDX_COUNT_HI, 8'h12);
    tmr_far_end_i.fall(1'b1);
    rd8(TMR_IDX_CTRL, 8'h48);
    chk_bit(eflag, 1'b1);
    rd8(TMR_IDX_COUNT_HI, 8'hFF);
    rd8(TMR_IDX_COUNT_LO, 8'hF0);
    wr8(TMR_IDX_CTRL, 8'h00);
    wr8(TMR_IDX_COUNT_HI, 8'h12);
    tmr_far_end_i.fall(1'b1);
    rd8(TMR_IDX_COUNT_HI, 8'h12);
    rd8(TMR_IDX_CTRL, 8'h00);
    wr8(TMR_IDX_COUNT_LO, 8'h00);
    wr8(TMR_IDX_COUNT_HI, 8'h00);
    wr8(TMR_IDX_CTRL, 8'h06);
    repeat (3) tmr_far_end_i.fall(1'b0);
    rd8(TMR_IDX_COUNT_LO, 8'h03);
    wr8(TMR_IDX_COUNT_HI, 8'hFF);
    wr8(TMR_IDX_COUNT_LO, 8'hF8);
    // Receive from this timer, transmit from timer 1
    rx0 = tmr_far_end_i.rx_n;
    tx0 = tmr_far_end_i.tx_n;
    ov0 = ovp_n;
    wr8(TMR_IDX_CTRL, 8'h24);
    pulse_t1();
    wr8(TMR_IDX_CTRL, 8'h20);
    rd8(TMR_IDX_CTRL, 8'h20);
    chk_bit(oflag, 1'b0);
    chk_rng(tmr_far_end_i.rx_n - rx0, 2, 4);
    chk_rng(tmr_far_end_i.tx_n - tx0, 5, 5);
    chk_rng(ovp_n - ov0, 2, 4);
    // Transmit from this timer, receive from timer 1
    wr8(TMR_IDX_COUNT_LO, 8'hF8);
    rx0 = tmr_far_end_i.rx_n;
    tx0 = tmr_far_end_i.tx_n;
    wr8(TMR_IDX_CTRL, 8'h14);
    pulse_t1();
    wr8(TMR_IDX_CTRL, 8'h10);
    rd8(TMR_IDX_CTRL, 8'h10);
    chk_rng(tmr_far_end_i.tx_n - tx0, 2, 4);
    chk_rng(tmr_far_end_i.rx_n - rx0, 5, 5);
    // Capture mode, stopped: trigger copies the count
    wr8(TMR_IDX_COUNT_LO, 8'h34);
    wr8(TMR_IDX_COUNT_HI, 8'h12);
    wr8(TMR_IDX_CTRL, 8'h09);
    tmr_far_end_i.fall(1'b1);
    rd8(TMR_IDX_RELOAD_HI, 8'h12);
    rd8(TMR_IDX_RELOAD_LO, 8'h34);
    rd8(TMR_IDX_COUNT_HI, 8'h12);
    rd8(TMR_IDX_CTRL, 8'h49);
    // Reset with the timer stopped and the event flag set
    i_resetn <= 1'h0;
    repeat (3) @(posedge i_clk);
    i_resetn <= 1'h1;
    @(posedge i_clk);
    rd8(TMR_IDX_CTRL, 8'h00);
    rd8(TMR_IDX_RELOAD_HI, 8'h00);
    chk_bit(eflag, 1'b0);
    conclude();
  end
endmodule // tb_tmr_auto_reload

// [tmr_auto_reload.sv]
// Sixteen-bit up-counting timer/counter with auto-reload, capture and
// serial baud clock selection, reached over an Avalon-MM slave.
// Assumes i_clk at 100 MHz, synchronous active-low reset, pins asynchronous.
//
// What this block does
// - Rollover from FFFFh sets flag outside baud mode and reloads; in capture mode the count wraps to 0000h.
// - External falling edge sets event flag; it reloads only outside capture and baud modes.
// - Auto-reload counts upward only.
// - Control register at C8h, resets to 00h.
// - Overflow flag hardware set, not in baud mode.
// - Event flag set by enabled trigger edge.
// - Receive select picks this overflow or timer 1.
// - Transmit select picks this overflow or timer 1.
// - External enable gates trigger pin activity.
// - Run control starts and stops counting.
// - Select counts internal ticks or external events.
`timescale 1ns/1ns
module tmr_auto_reload
  import tmr_pkg::*;
#(
  parameter int TICK_DIV = TMR_TICK_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Avalon-MM slave
  input wire logic [TMR_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [TMR_DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [TMR_DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Pins
  input wire logic i_external_trigger_pin,
  input wire logic i_count_pin,
  // Serial port zero baud clocks
  input wire logic i_t1_overflow,
  output logic o_rx_baud_tick,
  output logic o_tx_baud_tick,
  // Status
  output logic o_overflow_pulse,
  output logic o_overflow_flag,
  output logic o_external_event_flag
);

  // Registers
  tmr_ctrl_t ctrl_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic waitreq_ff;
  logic [TMR_DATA_W-1:0] rdata_ff;
  logic rx_baud_ff;
  logic tx_baud_ff;
  logic ovf_pulse_ff;

  // Combinational terms
  logic trig_fall;
  logic cnt_fall;
  logic tick;
  logic baud_mode;
  logic inc;
  logic ovf;
  logic ext;
  logic acc;
  logic wr;
  logic wr_ok;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic addr_ok;
  logic wr_ctrl;
  logic wr_cnt_lo;
  logic wr_cnt_hi;
  logic wr_rl_lo;
  logic wr_rl_hi;
  logic [7:0] nxt_rdata;
  logic [15:0] nxt_count;
  logic [15:0] nxt_reload;
  tmr_ctrl_t nxt_ctrl;

  // Pin synchronisers and edge pulses
  tmr_sync_fall u_trig_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_external_trigger_pin),
    .o_fall(trig_fall)
  );

  tmr_sync_fall u_count_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin(i_count_pin),
    .o_fall(cnt_fall)
  );

  tmr_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .o_tick(tick)
  );

  // Bus decode
  assign idx = i_avs_address[TMR_ADDR_W-1:2];
  assign acc = (i_avs_read | i_avs_write) & waitreq_ff;
  assign wr = i_avs_write & ~waitreq_ff;
  assign wr_ok = wr & i_avs_byteenable[0];
  assign wbyte = i_avs_writedata[7:0];
  assign addr_ok = (i_avs_address[1:0] == 2'b00);
  assign wr_ctrl = wr_ok & addr_ok & (idx == TMR_IDX_CTRL);
  assign wr_rl_lo = wr_ok & addr_ok & (idx == TMR_IDX_RELOAD_LO);
  assign wr_rl_hi = wr_ok & addr_ok & (idx == TMR_IDX_RELOAD_HI);
  assign wr_cnt_lo = wr_ok & addr_ok & (idx == TMR_IDX_COUNT_LO);
  assign wr_cnt_hi = wr_ok & addr_ok & (idx == TMR_IDX_COUNT_HI);

  // Mode and event terms
  assign baud_mode = ctrl_ff.receive_clock_select | ctrl_ff.transmit_clock_select;
  assign inc = ctrl_ff.run_control &
    (ctrl_ff.timer_counter_select ? cnt_fall : tick);
  assign ovf = inc & (count_ff == TMR_COUNT_MAX);
  assign ext = ctrl_ff.external_enable & trig_fall;

  // Read mux
  always_comb begin
    nxt_rdata = 8'h00;
    if (addr_ok) begin
      case (idx)
        TMR_IDX_CTRL: nxt_rdata = ctrl_ff;
        TMR_IDX_RELOAD_LO: nxt_rdata = reload_ff[7:0];
        TMR_IDX_RELOAD_HI: nxt_rdata = reload_ff[15:8];
        TMR_IDX_COUNT_LO: nxt_rdata = count_ff[7:0];
        TMR_IDX_COUNT_HI: nxt_rdata = count_ff[15:8];
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // One wait state, then the access completes
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      waitreq_ff <= 1'b1;
    end else if (acc) begin
      waitreq_ff <= 1'b0;
    end else begin
      waitreq_ff <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
    end else if (acc & i_avs_read) begin
      rdata_ff <= {24'h00_0000, nxt_rdata};
    end
  end

  // Counter: software write wins over counting
  always_comb begin
    nxt_count = count_ff;
    if (ctrl_ff.capture_reload_select & ~baud_mode) begin
      if (inc) begin
        nxt_count = count_ff + 16'h0001;
      end
    end else if (ovf | (ext & ~baud_mode)) begin
      nxt_count = reload_ff;
    end else if (inc) begin
      nxt_count = count_ff + 16'h0001;
    end
    if (wr_cnt_lo) begin
      nxt_count[7:0] = wbyte;
    end
    if (wr_cnt_hi) begin
      nxt_count[15:8] = wbyte;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      count_ff <= TMR_COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // Reload pair: capture takes the count on an enabled trigger edge
  always_comb begin
    nxt_reload = reload_ff;
    if (wr_rl_lo) begin
      nxt_reload[7:0] = wbyte;
    end
    if (wr_rl_hi) begin
      nxt_reload[15:8] = wbyte;
    end
    if (ctrl_ff.capture_reload_select & ~baud_mode & ext) begin
      nxt_reload = count_ff;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      reload_ff <= TMR_RELOAD_RST;
    end else begin
      reload_ff <= nxt_reload;
    end
  end

  // Control register; hardware flag set wins over a firmware clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      nxt_ctrl = wbyte;
    end
    if (ovf & ~baud_mode) begin
      nxt_ctrl.overflow_flag = 1'b1;
    end
    if (ext) begin
      nxt_ctrl.external_event_flag = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_ff <= TMR_CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Baud clock selection for serial port zero
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rx_baud_ff <= 1'b0;
      tx_baud_ff <= 1'b0;
      ovf_pulse_ff <= 1'b0;
    end else begin
      rx_baud_ff <= ctrl_ff.receive_clock_select ? ovf : i_t1_overflow;
      tx_baud_ff <= ctrl_ff.transmit_clock_select ? ovf : i_t1_overflow;
      ovf_pulse_ff <= ovf;
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = waitreq_ff;
  assign o_rx_baud_tick = rx_baud_ff;
  assign o_tx_baud_tick = tx_baud_ff;
  assign o_overflow_pulse = ovf_pulse_ff;
  assign o_overflow_flag = ctrl_ff.overflow_flag;
  assign o_external_event_flag = ctrl_ff.external_event_flag;

endmodule // tmr_auto_reload

// [tmr_auto_reload_assertions.sv]
// Checker for the auto-reload timer: bus handshake and flag behaviour.
// Assumes it is bound to tmr_auto_reload and sees its ports only.
`timescale 1ns/1ns
module tmr_chk
  import tmr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Bus
  input wire logic [TMR_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [TMR_DATA_W-1:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Status
  input wire logic o_overflow_pulse,
  input wire logic o_overflow_flag,
  input wire logic o_external_event_flag
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  logic wr_done;
  assign wr_done = i_avs_write && !o_avs_waitrequest;

  one_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("bus answer late");
  short_ack_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  byte_wide_a: assert property (i_avs_read && !o_avs_waitrequest
    |-> o_avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
  unmapped_zero_a: assert property (i_avs_read && !o_avs_waitrequest
    && i_avs_address[1:0] != 2'h0 |-> o_avs_readdata == '0) else $error("odd read not zero");
  ovf_sticky_a: assert property (o_overflow_flag && !wr_done |=> o_overflow_flag)
    else $error("overflow flag lost");
  exf_sticky_a: assert property (o_external_event_flag && !wr_done
    |=> o_external_event_flag) else $error("event flag lost");
  pulse_single_a: assert property (o_overflow_pulse |=> !o_overflow_pulse)
    else $error("overflow pulse too long");
  ovf_cause_a: assert property ($rose(o_overflow_flag) && !$past(wr_done)
    |-> ##[0:1] o_overflow_pulse) else $error("flag without overflow");
endmodule // tmr_chk

bind tmr_auto_reload tmr_chk tmr_chk_i (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_overflow_pulse(o_overflow_pulse), .o_overflow_flag(o_overflow_flag),
  .o_external_event_flag(o_external_event_flag));

// [tmr_far_end.sv]
// Far side model: trigger and count pins, serial baud tick consumer.
// Assumes pins idle high; the bench calls fall() right after a clock edge.
`timescale 1ns/1ns
module tmr_far_end (
  // Clock
  input wire logic i_clk,
  // Baud ticks
  input wire logic i_rx_baud_tick,
  input wire logic i_tx_baud_tick,
  // Pins
  output logic o_trigger_pin,
  output logic o_count_pin
);
  int rx_n = 0;
  int tx_n = 0;
  initial begin
    o_trigger_pin = 1'h1;
    o_count_pin = 1'h1;
  end
  always @(posedge i_clk) begin
    rx_n <= rx_n + int'(i_rx_baud_tick);
    tx_n <= tx_n + int'(i_tx_baud_tick);
  end
  // One falling edge on the chosen pin, held long enough to sync
  task automatic fall(input bit trig);
    if (trig) o_trigger_pin <= 1'h0;
    else o_count_pin <= 1'h0;
    repeat (4) @(posedge i_clk);
    o_trigger_pin <= 1'h1;
    o_count_pin <= 1'h1;
    repeat (4) @(posedge i_clk);
  endtask
endmodule // tmr_far_end

// [tmr_pkg.sv]
// Package for the auto-reload timer: register indices, fields, reset values.
// Assumes a 32-bit Avalon-MM slave with byte addresses of four times the index.
package tmr_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] TMR_IDX_CTRL = 8'hC8;
  localparam logic [7:0] TMR_IDX_RELOAD_LO = 8'hCA;
  localparam logic [7:0] TMR_IDX_RELOAD_HI = 8'hCB;
  localparam logic [7:0] TMR_IDX_COUNT_LO = 8'hCC;
  localparam logic [7:0] TMR_IDX_COUNT_HI = 8'hCD;

  localparam int TMR_ADDR_W = 10;
  localparam int TMR_DATA_W = 32;

  // Control register field positions
  localparam int TMR_BIT_OVF = 7;
  localparam int TMR_BIT_EXF = 6;
  localparam int TMR_BIT_RCLK = 5;
  localparam int TMR_BIT_TRANSMIT_CLOCK_SELECT = 4;
  localparam int TMR_BIT_EXEN = 3;
  localparam int TMR_BIT_RUN = 2;
  localparam int TMR_BIT_CT = 1;
  localparam int TMR_BIT_CPRL = 0;

  // Reset values
  localparam logic [7:0] TMR_CTRL_RST = 8'h00;
  localparam logic [15:0] TMR_COUNT_RST = 16'h0000;
  localparam logic [15:0] TMR_RELOAD_RST = 16'h0000;
  localparam logic [15:0] TMR_COUNT_MAX = 16'hFFFF;

  // Internal timer tick: one count every this many clocks
  localparam int TMR_TICK_DIV = 12;

  // Control register, bit 7 first
  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic receive_clock_select;
    logic transmit_clock_select;
    logic external_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } tmr_ctrl_t;

endpackage

// [tmr_sync_fall.sv]
// Two-flop synchroniser with a falling-edge pulse behind it.
// Assumes an asynchronous pin input; the pulse is one i_clk cycle wide.
`timescale 1ns/1ns
module tmr_sync_fall (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Pin and edge pulse
  input wire logic i_pin,
  output logic o_fall
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      last_ff <= 1'b1;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign o_fall = last_ff & ~sync_ff;
endmodule // tmr_sync_fall

// [tmr_tick_div.sv]
// Divider giving a one-cycle tick every DIV clocks.
// Assumes DIV of at least one.
`timescale 1ns/1ns
module tmr_tick_div #(
  parameter int DIV = 12
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Tick out
  output logic o_tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_ff;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cnt_ff <= '0;
    end else if (cnt_ff == LAST) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign o_tick = (cnt_ff == LAST);
endmodule // tmr_tick_div
